// ---- hdl/led_sink_serial_latch_loader.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "led_sink_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Event buffer: valid and ready on both sides, full and empty decoded from a registered count
module event_fifo #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Handshake decode
	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;
	assign out_data  = mem[rd_ptr_reg];

	// Storage array
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// Pointers and fill count
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Serial loader, trim and on/off latches, staggered channel drive
module led_sink_serial_latch_loader
	import led_sink_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic                      ce,
	input  wire logic                      serial_clk,
	input  wire logic                      serial_in,
	input  wire logic                      latch_strobe,
	input  wire logic                      mode,
	input  wire logic                      blank_n,
	input  wire logic [`CHANNELS-1:0]      open_led_detect,
	output logic                           serial_out,
	output logic [`CHANNELS-1:0]           sink_channel,
	output logic [`TRIM_TOTAL-1:0]         intensity_trim,
	output logic                           in_ready,
	output logic                           fifo_overrun
);
	localparam int STG = `STAGGER_CYCLES;
	localparam int HD  = (`CHANNELS - 1) * STG;
	localparam int SW  = `SYNC_WIDTH;
	localparam logic [4:0] SAMPLE_CYC = 5'(`LOD_SAMPLE_CYCLES);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, a level counts once stages two and three agree
	logic [SW-1:0] pins;
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;
	logic [SW-1:0] sync3_reg;
	logic [SW-1:0] level_reg;
	logic [SW-1:0] level_next;

	assign pins = {open_led_detect, blank_n, mode, latch_strobe, serial_in, serial_clk};

	genvar g;
	generate
		for (g = 0; g < SW; g++)
		begin : gen_filter
			assign level_next[g] = (sync2_reg[g] == sync3_reg[g]) ? sync3_reg[g] : level_reg[g];
		end
	endgenerate

	// Synchroniser chain and filtered levels
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			level_reg <= '0;
		end
		else if (ce)
		begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= level_next;
		end
	end

	// Decoded pin events and levels
	logic                 sclk_rise;
	logic                 strobe_rise;
	logic                 bit_level;
	logic                 mode_level;
	logic                 blank_level;
	logic [`CHANNELS-1:0] detect_level;

	assign sclk_rise    = level_next[0] && !level_reg[0];
	assign strobe_rise  = level_next[2] && !level_reg[2];
	assign bit_level    = level_next[1];
	assign mode_level   = level_next[3];
	assign blank_level  = level_reg[4];
	assign detect_level = level_reg[SW-1:5];

	////////////////////////////////////////////////////////////////////////////
	// Event buffer between pin decode and the shift register
	serial_event_type ev_in;
	serial_event_type ev_out;
	logic             ev_in_valid;
	logic             ev_in_ready;
	logic             ev_out_valid;
	logic             ev_out_ready;
	logic             sample_busy;

	// A strobe rise wins over a coincident clock rise, which the host timing forbids
	assign ev_in.latch     = strobe_rise;
	assign ev_in.trim_mode = mode_level;
	assign ev_in.data      = bit_level;
	assign ev_in_valid     = strobe_rise || sclk_rise;
	// A latch waits while open status is still being sampled
	assign ev_out_ready    = !(ev_out.latch && sample_busy);

	event_fifo #(
		.WIDTH ($bits(serial_event_type)),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.ce        (ce),
		.in_data   (ev_in),
		.in_valid  (ev_in_valid),
		.in_ready  (ev_in_ready),
		.out_data  (ev_out),
		.out_valid (ev_out_valid),
		.out_ready (ev_out_ready)
	);

	logic do_event;
	logic do_shift;
	logic do_trim_latch;
	logic do_onoff_latch;

	assign do_event       = ce && ev_out_valid && ev_out_ready;
	assign do_shift       = do_event && !ev_out.latch;
	assign do_trim_latch  = do_event && ev_out.latch && ev_out.trim_mode;
	assign do_onoff_latch = do_event && ev_out.latch && !ev_out.trim_mode;

	////////////////////////////////////////////////////////////////////////////
	// Input shift register, trim latch and on/off latch
	logic [`TRIM_TOTAL-1:0] shift_reg;
	logic [`TRIM_TOTAL-1:0] trim_reg;
	logic [`CHANNELS-1:0]   onoff_reg;
	logic [`CHANNELS-1:0]   pending_reg;
	logic                   shift_out_bit;

	// Tap follows the filtered mode pin, so it is defined even while the buffer is empty
	assign shift_out_bit = mode_level ? shift_reg[`TRIM_TOTAL-1]
		: shift_reg[`ONOFF_TOTAL-1];

	// Shift, latch and status reload; all cleared at reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			shift_reg <= '0;
			trim_reg  <= '0;
			onoff_reg <= '0;
		end
		else
		begin
			if (do_shift)
				shift_reg <= {shift_reg[`TRIM_TOTAL-2:0], ev_out.data};
			else if (do_onoff_latch)
				shift_reg[`ONOFF_TOTAL-1:0] <= pending_reg;
			if (do_trim_latch)
				trim_reg <= shift_reg;
			if (do_onoff_latch)
				onoff_reg <= shift_reg[`ONOFF_TOTAL-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Open status sampler: waits after each on/off latch, then captures lit opens
	sample_state_type state_reg;
	sample_state_type state_next;
	logic [4:0]       wait_reg;

	assign sample_busy = (state_reg == SAMPLE_WAIT);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			SAMPLE_IDLE: if (do_onoff_latch) state_next = SAMPLE_WAIT;
			SAMPLE_WAIT: if (ce && wait_reg == SAMPLE_CYC) state_next = SAMPLE_IDLE;
		endcase
	end

	// Timer and pending status word
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg   <= SAMPLE_IDLE;
			wait_reg    <= '0;
			pending_reg <= '0;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			if (state_reg == SAMPLE_IDLE)
				wait_reg <= '0;
			else
				wait_reg <= wait_reg + 1'b1;
			if (sample_busy && wait_reg == SAMPLE_CYC)
				pending_reg <= detect_level & onoff_reg & {`CHANNELS{!blank_level}};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel drive: blank gates all, then a delay line staggers each channel
	logic [`CHANNELS-1:0] target;
	logic [`CHANNELS-1:0] hist_reg [HD];
	logic [`CHANNELS-1:0] drive_reg;

	assign target = blank_level ? '0 : onoff_reg;

	// Delay history of the gated target
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < HD; i++)
				hist_reg[i] <= '0;
		end
		else if (ce)
		begin
			hist_reg[0] <= target;
			for (int i = 1; i < HD; i++)
				hist_reg[i] <= hist_reg[i-1];
		end
	end

	// Channel k sees the target k stagger steps plus one register cycle late
	generate
		for (g = 0; g < `CHANNELS; g++)
		begin : gen_stagger
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
					drive_reg[g] <= 1'b0;
				else if (ce)
					drive_reg[g] <= (g == 0) ? target[g] : hist_reg[(g == 0) ? 0 : g*STG-1][g];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	logic serial_out_reg;
	logic in_ready_reg;
	logic overrun_reg;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			serial_out_reg <= 1'b0;
			in_ready_reg   <= 1'b0;
			overrun_reg    <= 1'b0;
		end
		else if (ce)
		begin
			serial_out_reg <= shift_out_bit;
			in_ready_reg   <= ev_in_ready;
			if (ev_in_valid && !ev_in_ready)
				overrun_reg <= 1'b1;  // Sticky until reset
		end
	end

	assign serial_out     = serial_out_reg;
	assign sink_channel   = drive_reg;
	assign intensity_trim = trim_reg;
	assign in_ready       = in_ready_reg;
	assign fifo_overrun   = overrun_reg;
endmodule

`default_nettype wire

// ---- hdl/led_sink_defs.svh ----
`ifndef LED_SINK_DEFS_SVH
`define LED_SINK_DEFS_SVH

`define CHANNELS         16
`define TRIM_BITS        7
`define TRIM_TOTAL       112
`define ONOFF_TOTAL      16
`define TRIM_MAX_CODE    7'h7f
`define CLK_PERIOD_NS    100
`define STAGGER_NS       20
`define STAGGER_CYCLES   (((`STAGGER_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`STAGGER_NS / `CLK_PERIOD_NS))
`define STATUS_INTERVAL_NS 1660
`define LOD_SAMPLE_NS    1500
`define LOD_SAMPLE_CYCLES (`LOD_SAMPLE_NS / `CLK_PERIOD_NS)
`define FIFO_DEPTH       16
`define SYNC_WIDTH       21

`endif

// ---- hdl/led_sink_pkg.sv ----
`default_nettype none
package led_sink_pkg;

	// One decoded serial event carried through the buffer
	typedef struct packed {
		logic latch;     // Strobe rise rather than a data bit
		logic trim_mode; // Mode level at the event
		logic data;      // Serial data bit
	} serial_event_type;

	typedef enum logic [0:0] {
		SAMPLE_IDLE,
		SAMPLE_WAIT
	} sample_state_type;

endpackage
`default_nettype wire

// ---- verification/led_sink_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "led_sink_defs.svh"
// Port checks for the serial latch loader
module led_sink_monitor (
	input wire logic                    clk,
	input wire logic                    reset,
	input wire logic                    serial_clk,
	input wire logic                    latch_strobe,
	input wire logic                    mode,
	input wire logic                    blank_n,
	input wire logic                    serial_out,
	input wire logic [`CHANNELS-1:0]    sink_channel,
	input wire logic [`TRIM_TOTAL-1:0]  intensity_trim,
	input wire logic                    in_ready
);
	logic [7:0] stb_age;
	logic [7:0] edge_age;
	logic [7:0] blank_age;
	logic [7:0] blank_cnt;
	logic       stb_mode;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	function automatic logic [7:0] inc(input logic [7:0] x);
		return x + {7'h00, ~&x};
	endfunction
	// Saturating ages since each cause of an output change
	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			stb_age <= 8'hff;
			edge_age <= 8'hff;
			blank_age <= 8'hff;
			blank_cnt <= 8'h00;
			stb_mode <= 1'b0;
		end
		else
		begin
			stb_age <= $rose(latch_strobe) ? 8'h00 : inc(stb_age);
			edge_age <= ($rose(serial_clk) || $rose(latch_strobe) || $changed(mode)) ?
				8'h00 : inc(edge_age);
			blank_age <= $changed(blank_n) ? 8'h00 : inc(blank_age);
			blank_cnt <= blank_n ? inc(blank_cnt) : 8'h00;
			stb_mode <= $rose(latch_strobe) ? mode : stb_mode;
		end
	// Output relations
	a_reset_clears: assert property ($fell(reset) |->
		sink_channel == '0 && intensity_trim == '0 && !serial_out) else $error("not cleared");
	a_ready_up: assert property ($fell(reset) |=> in_ready)
		else $error("in_ready low");
	a_blank_off: assert property (blank_cnt >= 8'h18 |-> sink_channel == '0)
		else $error("on while blanked");
	a_trim_cause: assert property ($changed(intensity_trim) |-> stb_age <= 8'h0c)
		else $error("trim moved alone");
	a_trim_mode: assert property ($changed(intensity_trim) |-> stb_mode)
		else $error("trim in on/off mode");
	a_sink_stagger: assert property ($onehot0(sink_channel ^ $past(sink_channel)))
		else $error("channels not staggered");
	a_sink_cause: assert property ($changed(sink_channel) |->
		stb_age <= 8'h30 || blank_age <= 8'h18) else $error("channel moved alone");
	a_out_cause: assert property ($changed(serial_out) |-> edge_age <= 8'h18)
		else $error("serial_out moved alone");
	c_trim: cover property ($changed(intensity_trim));
	c_sink: cover property ($changed(sink_channel));
	c_blank: cover property (blank_cnt == 8'h18);
endmodule
////////////////////////////////////////
bind led_sink_serial_latch_loader led_sink_monitor i_led_sink_monitor (
	.clk(clk), .reset(reset), .serial_clk(serial_clk), .latch_strobe(latch_strobe),
	.mode(mode), .blank_n(blank_n), .serial_out(serial_out), .sink_channel(sink_channel),
	.intensity_trim(intensity_trim), .in_ready(in_ready));
`default_nettype wire

// ---- verification/led_sink_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host controller on the serial pins
module led_sink_host (
	input  wire logic clk,
	input  wire logic serial_out,
	output var logic  serial_clk,
	output var logic  serial_in,
	output var logic  latch_strobe,
	output var logic  mode
);
	logic [111:0] got;
	// Pins idle low from time zero
	initial
	begin
		serial_clk = 1'b0;
		serial_in = 1'b0;
		latch_strobe = 1'b0;
		mode = 1'b0;
		got = '0;
	end
	// One bit; data flipped after the high phase so a stale level never helps
	task automatic bit_out(input logic d);
		serial_in = d;
		repeat (5) @(negedge clk);
		got = {got[110:0], serial_out};
		serial_clk = 1'b1;
		repeat (5) @(negedge clk);
		serial_clk = 1'b0;
		serial_in = ~d;
	endtask
	// Whole packet, first bit for the top channel, then a latch pulse
	task automatic send(input logic [111:0] v, input int n, input logic m);
		mode = m;
		for (int i = n - 1; i >= 0; i--)
			bit_out(v[i]);
		repeat (5) @(negedge clk);
		latch_strobe = 1'b1;
		repeat (5) @(negedge clk);
		latch_strobe = 1'b0;
		repeat (15) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ---- verification/led_sink_serial_latch_loader_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "led_sink_defs.svh"
module led_sink_serial_latch_loader_tb;
	localparam logic [111:0] TRIM = 112'hfe0123456789abcdef0123456789;
	logic         clk = 1'b0;
	logic         reset = 1'b1;
	logic         blank_n = 1'b1;
	logic [15:0]  open_led_detect = 16'h0ff0;
	wire logic    serial_clk;
	wire logic    serial_in;
	wire logic    latch_strobe;
	wire logic    mode;
	wire logic    serial_out;
	wire logic    in_ready;
	wire logic    fifo_overrun;
	wire logic [15:0]  sink_channel;
	wire logic [111:0] intensity_trim;
	int           fail_count = 0;
	int           n_tests = 0;
	always #50 clk = ~clk;
	led_sink_serial_latch_loader i_led_sink_serial_latch_loader (
		.clk(clk), .reset(reset), .ce(1'b1), .serial_clk(serial_clk), .serial_in(serial_in),
		.latch_strobe(latch_strobe), .mode(mode), .blank_n(blank_n),
		.open_led_detect(open_led_detect), .serial_out(serial_out),
		.sink_channel(sink_channel), .intensity_trim(intensity_trim),
		.in_ready(in_ready), .fifo_overrun(fifo_overrun));
	led_sink_host i_led_sink_host (
		.clk(clk), .serial_out(serial_out), .serial_clk(serial_clk),
		.serial_in(serial_in), .latch_strobe(latch_strobe), .mode(mode));
	// Compare one result
	task automatic check(input logic [111:0] g, input logic [111:0] e);
		n_tests++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Tests take about 2000 cycles; cut a hang at 1 ms
	initial
	begin
		#1000000;
		fail_count++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end
	////////////////////////////////////////
	// Test sequence
	initial
	begin
		repeat (20) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		check(sink_channel, '0);
		check(intensity_trim, '0);
		check(serial_out, '0);
		check(in_ready, 1'b1);
		$display("test reset done");
		blank_n = 1'b0;
		i_led_sink_host.send(16'ha5c3, 16, 1'b0);
		repeat (30) @(negedge clk);
		check(sink_channel, 16'ha5c3);
		$display("test onoff done");
		i_led_sink_host.send(TRIM, 112, 1'b1);
		repeat (30) @(negedge clk);
		check(intensity_trim, TRIM);
		check(sink_channel, 16'ha5c3);
		$display("test trim done");
		i_led_sink_host.send(16'h3c3c, 16, 1'b0);
		repeat (30) @(negedge clk);
		check(sink_channel, 16'h3c3c);
		blank_n = 1'b1;
		repeat (30) @(negedge clk);
		check(sink_channel, '0);
		blank_n = 1'b0;
		repeat (30) @(negedge clk);
		check(sink_channel, 16'h3c3c);
		$display("test blank done");
		i_led_sink_host.send(16'h0000, 16, 1'b0);
		check(i_led_sink_host.got[15:0], 16'h05c0);
		repeat (30) @(negedge clk);
		check(sink_channel, '0);
		check(fifo_overrun, '0);
		check(in_ready, 1'b1);
		$display("test status done");
		print_verdict();
	end
endmodule
`default_nettype wire
